// *** shared/spb_params.svh ***
// Holds the offsets, field positions, reset values and timing counts
// of the serial-to-parallel printer bridge.
// Assumes inclusion by bare name from design and bench files.
`ifndef SPB_PARAMS_SVH
`define SPB_PARAMS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define SPB_ADDR_CTRL   4'h0
`define SPB_ADDR_STATUS 4'h4
`define SPB_ADDR_BAUD   4'h8
`define SPB_ADDR_DATA   4'hC

// ****************************************
// Control field positions and reset
// ****************************************
`define SPB_CTRL_EN     0
`define SPB_CTRL_LOOP   1
`define SPB_CTRL_FMT_LO 2
`define SPB_CTRL_FMT_HI 3
`define SPB_CTRL_VFU    4
`define SPB_CTRL_DSRDCD 5
`define SPB_CTRL_CTS    6
`define SPB_CTRL_RST    7'h00

// ****************************************
// Status field positions
// ****************************************
`define SPB_ST_LINK     0
`define SPB_ST_READY    1
`define SPB_ST_OVERRUN  2
`define SPB_ST_STROBE   3
`define SPB_ST_TXBUSY   4
`define SPB_ST_ONLINE   5
`define SPB_ST_FRAMEERR 6

// ****************************************
// Flow-control codes and line timing
// ****************************************
`define SPB_XON         8'h11
`define SPB_XOFF        8'h13
`define SPB_CLK_HZ      40000000
`define SPB_BAUD_BPS    9600
`define SPB_BAUD_DIV    (`SPB_CLK_HZ / `SPB_BAUD_BPS)

`endif

// *** shared/spb_pkg.sv ***
// Holds the types shared by the printer bridge modules.
// Assumes nothing beyond a SystemVerilog compiler.
package spb_pkg;

   // ****************************************
   // Modes and states
   // ****************************************
   typedef enum logic [1:0] {
      FMT_SIMPLEX,
      FMT_UNBLOCKED,
      FMT_BLOCKED
   } spb_fmt_t;

   typedef enum logic {
      PAR_IDLE,
      PAR_STROBE
   } spb_par_st_t;

   // ****************************************
   // Signal carriers
   // ****************************************
   typedef struct packed {
      logic ready;
      logic request;
      logic online;
   } spb_par_in_t;

   typedef struct packed {
      logic       strobe;
      logic [7:0] data;
   } spb_par_out_t;

   typedef struct packed {
      logic dsr;
      logic dcd;
      logic cts;
   } spb_ctl_in_t;

   typedef struct packed {
      logic dtr_n;
      logic rts_n;
      logic srts_n;
      logic txd;
      logic ploop;
      logic aloop;
   } spb_mdm_out_t;

endpackage

// *** tb/spb_bridge_assertions.sv ***
// Checker for the printer bridge, watching the top module's ports.
// Assumes it is bound onto spb_bridge; mirrors CTRL writes itself.
`timescale 1ns/1ps
`include "spb_params.svh"
module spb_bridge_assertions #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic                  i_clk_sys,
   input wire logic                  i_rst_n,
   // Register port
   input wire logic [3:0]            i_addr,
   input wire logic [31:0]           i_wdata,
   input wire logic                  i_wr,
   input wire logic                  i_rd,
   input wire logic [31:0]           o_rdata,
   // Serial side
   input wire logic                  i_rxd,
   input wire logic                  i_rxd_loop,
   input wire spb_pkg::spb_ctl_in_t  i_ctl,
   input wire spb_pkg::spb_mdm_out_t o_mdm,
   // Parallel side
   input wire spb_pkg::spb_par_in_t  i_par,
   input wire spb_pkg::spb_par_out_t o_par
);
   import spb_pkg::*;
   logic vfu_reg;
   logic loop_reg;
   logic vfu_d_reg;
   logic loop_d_reg;
   logic calm;
   logic act;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // ********
   // Mode bits mirrored from bus writes
   // ********
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vfu_reg    <= 1'b0;
         loop_reg   <= 1'b0;
         vfu_d_reg  <= 1'b0;
         loop_d_reg <= 1'b0;
      end else begin
         vfu_d_reg  <= vfu_reg;
         loop_d_reg <= loop_reg;
         if (i_wr && i_addr == `SPB_ADDR_CTRL) begin
            vfu_reg  <= i_wdata[`SPB_CTRL_VFU];
            loop_reg <= i_wdata[`SPB_CTRL_LOOP];
         end
      end
   end
   // One settle cycle hides a registered output after a mode write
   assign calm = (vfu_reg == vfu_d_reg) && (loop_reg == loop_d_reg);
   assign act  = o_par.strobe ^ vfu_reg;
   // ********
   // Properties
   // ********
   a_modem_pair: assert property (
      o_mdm.dtr_n == o_mdm.rts_n) else $error("dtr and rts differ");
   a_link_cause: assert property (
      $fell(o_mdm.dtr_n) |-> $past(i_par.ready) && $past(i_par.request))
      else $error("link up without ready and request");
   a_strobe_cause: assert property (
      $rose(act) && calm |-> !o_mdm.dtr_n && $past(i_par.request)
         && $past(i_par.ready)) else $error("strobe without cause");
   a_strobe_hold: assert property (
      act && calm && i_par.request |=> act) else $error("strobe dropped early");
   a_strobe_drop: assert property (
      act && calm && !i_par.request |=> !act) else $error("strobe not dropped");
   a_data_steady: assert property (
      act && calm ##1 act |-> $stable(o_par.data))
      else $error("data moved under strobe");
   a_busy_hold: assert property (
      act && calm |-> o_mdm.srts_n) else $error("ready shown while busy");
   a_srts_link: assert property (
      $fell(o_mdm.srts_n) |-> ##[0:1] !o_mdm.dtr_n)
      else $error("secondary request without link");
   a_volt_aloop: assert property (
      calm && !loop_reg |-> o_mdm.aloop) else $error("active loop busy");
   a_loop_txd: assert property (
      calm && loop_reg |-> o_mdm.txd) else $error("voltage line busy");
   a_ploop_mode: assert property (
      calm && o_mdm.ploop |-> loop_reg) else $error("passive loop in voltage");
endmodule // spb_bridge_assertions

bind spb_bridge spb_bridge_assertions #(.DIV_W(DIV_W)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_rxd(i_rxd), .i_rxd_loop(i_rxd_loop), .i_ctl(i_ctl),
   .o_mdm(o_mdm), .i_par(i_par), .o_par(o_par));

// *** tb/spb_host_model.sv ***
// User host model: 8N1 sender on either line, receiver of status bytes.
// Assumes a fixed bit time in clock cycles, equal to the BAUD setting.
`timescale 1ns/1ps
module spb_host_model #(
   parameter int BIT = 16
) (
   // Clock and line select
   input  wire logic i_clk_sys,
   input  wire logic i_sel_loop,
   // Lines
   input  wire logic i_line,
   output logic      o_rxd,
   output logic      o_rxd_loop,
   // Received byte
   output logic      o_got,
   output logic [7:0] o_byte
);
   initial begin
      o_rxd      = 1'b1;
      o_rxd_loop = 1'b1;
      o_got      = 1'b0;
      o_byte     = 8'h00;
   end
   // Start bit first, LSB first, idle mark between frames
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk_sys);
         if (i_sel_loop) o_rxd_loop <= f[i];
         else o_rxd <= f[i];
         repeat (BIT - 1) @(posedge i_clk_sys);
      end
   endtask
   // Mid-bit sampling; pulse lasts one cycle
   always begin
      @(negedge i_line);
      repeat (BIT / 2) @(posedge i_clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge i_clk_sys);
         o_byte[i] <= i_line;
      end
      repeat (BIT) @(posedge i_clk_sys);
      o_got <= 1'b1;
      @(posedge i_clk_sys);
      o_got <= 1'b0;
   end
endmodule // spb_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the printer bridge.
// Assumes the host model and the bound checker in the same compile.
`timescale 1ns/1ps
`include "spb_params.svh"
module tb_top;
   import spb_pkg::*;
   localparam int BIT = 16;
   logic         clk;
   logic         rst_n;
   logic [3:0]   addr;
   logic [31:0]  wdata;
   logic         wr_s;
   logic         rd_s;
   logic [31:0]  rdata;
   logic         rxd;
   logic         rxd_loop;
   logic         sel_loop;
   logic         vertical_format_option;
   logic         stall;
   logic         got;
   logic [7:0]   hb;
   logic         rd_d;
   logic         seen_d;
   logic         seen;
   spb_ctl_in_t  ctl;
   spb_mdm_out_t mdm;
   spb_par_in_t  par;
   spb_par_out_t pout;
   int           error_cnt;
   int           checks;
   logic [31:0]  exp_rd[$];
   logic [7:0]   exp_par[$];
   logic [7:0]   exp_host[$];
   spb_bridge #(.DIV_W(16)) dut (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
      .i_rxd(rxd), .i_rxd_loop(rxd_loop), .i_ctl(ctl), .o_mdm(mdm),
      .i_par(par), .o_par(pout));
   spb_host_model #(.BIT(BIT)) host (
      .i_clk_sys(clk), .i_sel_loop(sel_loop),
      .i_line(mdm.txd & mdm.aloop), .o_rxd(rxd),
      .o_rxd_loop(rxd_loop), .o_got(got), .o_byte(hb));
   // Strobe seen active only while the link is up and the hold busy
   assign seen = (pout.strobe ^ vertical_format_option) & ~mdm.dtr_n & mdm.srts_n;
   always #12.5 clk = ~clk;
   // ********
   // Tasks
   // ********
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      addr <= a;
      rd_s <= 1'b1;
      exp_rd.push_back(e);
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Parallel card: holds request until strobe, drops after a random delay
   always begin
      int n;
      @(posedge clk);
      if (seen && par.request && !stall) begin
         // Format card: 2.5 us delay before its answer, 100 clock cycles
         if (vertical_format_option) repeat (100) @(posedge clk);
         repeat ($urandom_range(1, 4)) @(posedge clk);
         par.request <= 1'b0;
         for (n = 0; n < 50 && seen; n++) @(posedge clk);
         check(seen, 1'b0);
         par.request <= 1'b1;
      end
   end
   // Result watcher: oldest note against each result that shows up
   always @(posedge clk) begin
      if (rd_d) check(rdata, exp_rd.pop_front());
      if (seen && !seen_d) check(pout.data, exp_par.pop_front());
      if (got) begin
         if (exp_host.size() == 0) check(hb, 32'hFFFF);
         else check(hb, exp_host.pop_front());
      end
      rd_d   <= rd_s;
      seen_d <= seen;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      check(1'b1, 1'b0);
      print_verdict;
   end
   // ********
   // Main sequence
   // ********
   initial begin
      logic [7:0] b;
      clk = 1'b0;
      rst_n = 1'b0;
      {addr, wdata, wr_s, rd_s, rd_d, seen_d} = '0;
      {sel_loop, vertical_format_option, stall, error_cnt, checks} = '0;
      ctl = 3'h7;
      par = 3'h0;
      b = 8'($urandom(54));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(mdm, 6'h3D);
      check(pout, 9'h000);
      rd(`SPB_ADDR_CTRL, 32'h0);
      rd(`SPB_ADDR_BAUD, 32'h1046);
      rd(`SPB_ADDR_STATUS, 32'h0);
      wr(4'h2, 32'hFF);
      rd(4'h2, 32'h0);
      wr(`SPB_ADDR_BAUD, BIT);
      rd(`SPB_ADDR_BAUD, BIT);
      $display("test reset done");
      par <= 3'h7;
      for (int f = 0; f < 4; f++) begin
         wr(`SPB_ADDR_CTRL, 32'h0);
         if (f == 1 || f == 2) exp_host.push_back(`SPB_XON);
         wr(`SPB_ADDR_CTRL, 32'h1 | (f << 2));
         idle(3);
         check({mdm.dtr_n, mdm.rts_n, mdm.srts_n}, 3'h0);
         idle(12 * BIT);
         check(exp_host.size(), 0);
      end
      $display("test formats done");
      for (int i = 0; i < 6; i++) begin
         b = 8'($urandom);
         exp_par.push_back(b);
         host.send(b);
      end
      idle(40);
      check(exp_par.size(), 0);
      rd(`SPB_ADDR_STATUS, 32'h21);
      $display("test stream done");
      wr(`SPB_ADDR_CTRL, 32'h0);
      exp_host.push_back(`SPB_XON);
      wr(`SPB_ADDR_CTRL, 32'h9);
      idle(12 * BIT);
      stall <= 1'b1;
      b = 8'($urandom);
      exp_par.push_back(b);
      exp_host.push_back(`SPB_XOFF);
      host.send(b);
      host.send(~b);
      idle(12 * BIT);
      check(pout.data, b);
      rd(`SPB_ADDR_STATUS, 32'h2F);
      rd(`SPB_ADDR_DATA, {24'h0, b});
      exp_host.push_back(`SPB_XON);
      stall <= 1'b0;
      idle(12 * BIT);
      wr(`SPB_ADDR_STATUS, 32'h4);
      rd(`SPB_ADDR_STATUS, 32'h21);
      $display("test overrun done");
      wr(`SPB_ADDR_CTRL, 32'h0);
      idle(3);
      wr(`SPB_ADDR_CTRL, 32'h10);
      vertical_format_option <= 1'b1;
      idle(2);
      check(pout.strobe, 1'b1);
      sel_loop <= 1'b1;
      exp_host.push_back(`SPB_XON);
      wr(`SPB_ADDR_CTRL, 32'h57);
      idle(3);
      check({mdm.txd, mdm.ploop}, 2'h3);
      b = 8'($urandom);
      exp_host.push_back(b);
      wr(`SPB_ADDR_DATA, b);
      b = 8'($urandom);
      exp_par.push_back(b);
      host.send(b);
      idle(12 * BIT);
      $display("test loop done");
      wr(`SPB_ADDR_CTRL, 32'h10);
      idle(3);
      wr(`SPB_ADDR_CTRL, 32'h0);
      {vertical_format_option, sel_loop} <= 2'h0;
      ctl <= 3'h1;
      wr(`SPB_ADDR_CTRL, 32'h21);
      host.send(8'h5A);
      idle(20);
      rd(`SPB_ADDR_STATUS, 32'h21);
      ctl <= 3'h7;
      b = 8'($urandom);
      exp_par.push_back(b);
      host.send(b);
      idle(40);
      wr(`SPB_ADDR_CTRL, 32'h0);
      host.send(8'hA5);
      idle(20);
      rd(`SPB_ADDR_STATUS, 32'h20);
      check(exp_par.size() + exp_host.size(), 0);
      $display("test refusal done");
      print_verdict;
   end
endmodule // tb_top

// *** verilog/spb_bridge.sv ***
// Holds the serial-to-parallel printer bridge: serial receiver with a
// one-byte hold, flow control toward the user, and the strobe handshake
// toward the parallel interface card.
// Assumes all pins synchronous to i_clk_sys; the analog line drivers
// and the card's own print handshakes sit outside.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "spb_params.svh"

module spb_bridge #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_n,
   // Register port
   input  wire logic [3:0]           i_addr,
   input  wire logic [31:0]          i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic [31:0]               o_rdata,
   // Serial side
   input  wire logic                 i_rxd,
   input  wire logic                 i_rxd_loop,
   input  wire spb_pkg::spb_ctl_in_t i_ctl,
   output spb_pkg::spb_mdm_out_t     o_mdm,
   // Parallel side
   input  wire spb_pkg::spb_par_in_t i_par,
   output spb_pkg::spb_par_out_t     o_par
);
   import spb_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [6:0]       ctrl;
      logic [DIV_W-1:0] baud;
      logic             link;
      logic             hold_full;
      logic [7:0]       hold;
      logic             overrun;
      logic             frame_err;
      spb_par_st_t      pst;
      logic             xon_pend;
      logic             xoff_sent;
      logic             sw_pend;
      logic [7:0]       sw_byte;
      logic [31:0]      rdata;
   } spb_top_state_t;

   spb_top_state_t q_reg, q_next;

   logic             rx_valid;
   logic             rx_ferr;
   logic [7:0]       rx_data;
   logic             tx_line;
   logic             tx_busy;
   logic             tx_start;
   logic [7:0]       tx_byte;
   logic             rx_line;
   logic             rx_en;
   logic             loop_mode;
   logic             vertical_format_option;
   spb_fmt_t         fmt;
   logic             duplex;
   logic             want_off;
   logic             tx_ok;
   logic             deliver;

   // Divider resets to the 9600 baud count, which needs 13 bits; a
   // narrower counter would wrap to a wrong rate out of reset
   if (DIV_W < 13) $error("spb_bridge: DIV_W cannot hold baud reset");

   // ****************************************
   // Mode decode
   // ****************************************
   // Line method and strobe polarity straight from control bits
   assign loop_mode = q_reg.ctrl[`SPB_CTRL_LOOP];
   assign vertical_format_option       = q_reg.ctrl[`SPB_CTRL_VFU];

   // Unused fourth code falls back to simplex
   always_comb begin
      unique case (q_reg.ctrl[`SPB_CTRL_FMT_HI:`SPB_CTRL_FMT_LO])
         2'h1:    fmt = FMT_UNBLOCKED;
         2'h2:    fmt = FMT_BLOCKED;
         default: fmt = FMT_SIMPLEX;
      endcase
   end

   assign duplex = (fmt != FMT_SIMPLEX);

   // Receive line source and gating by user modem lines
   assign rx_line = loop_mode ? i_rxd_loop : i_rxd;
   assign rx_en   = q_reg.link &&
                    (!q_reg.ctrl[`SPB_CTRL_DSRDCD] ||
                     (i_ctl.dsr && i_ctl.dcd));

   // ****************************************
   // Transmit arbitration
   // ****************************************
   // Blocked duplex mirrors the hold state with XOFF and XON
   assign want_off = (fmt == FMT_BLOCKED) && q_reg.hold_full;
   // CTS is honoured only when software asks for it
   assign tx_ok    = !tx_busy && q_reg.link && duplex &&
                     (!q_reg.ctrl[`SPB_CTRL_CTS] || i_ctl.cts);

   // Opening XON first, then flow codes, then status bytes
   always_comb begin
      tx_start = 1'b0;
      tx_byte  = `SPB_XON;
      if (tx_ok) begin
         if (q_reg.xon_pend) begin
            tx_start = 1'b1;
            tx_byte  = `SPB_XON;
         end else if (want_off != q_reg.xoff_sent) begin
            tx_start = 1'b1;
            tx_byte  = want_off ? `SPB_XOFF : `SPB_XON;
         end else if (q_reg.sw_pend) begin
            tx_start = 1'b1;
            tx_byte  = q_reg.sw_byte;
         end
      end
   end

   // Handshake finishing this cycle frees the hold
   assign deliver = (q_reg.pst == PAR_STROBE) && !i_par.request;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      q_next       = q_reg;
      q_next.rdata = 32'h0000_0000;

      // Link comes up on ready and request, falls with ready or enable
      if (!q_reg.ctrl[`SPB_CTRL_EN] || !i_par.ready) begin
         q_next.link     = 1'b0;
         q_next.xon_pend = 1'b0;
      end else if (!q_reg.link && i_par.request) begin
         q_next.link     = 1'b1;
         q_next.xon_pend = duplex;
      end

      // Transmit bookkeeping
      if (tx_start) begin
         if (q_reg.xon_pend) begin
            q_next.xon_pend = 1'b0;
         end else if (want_off != q_reg.xoff_sent) begin
            q_next.xoff_sent = want_off;
         end else begin
            q_next.sw_pend = 1'b0;
         end
      end
      if (!q_reg.link) q_next.xoff_sent = 1'b0;

      // Parallel handshake; strobe held until request falls
      unique case (q_reg.pst)
         PAR_IDLE: begin
            if (q_reg.hold_full && i_par.ready && i_par.request &&
                q_reg.link) begin
               q_next.pst = PAR_STROBE;
            end
         end
         PAR_STROBE: begin
            if (!i_par.request) begin
               q_next.pst       = PAR_IDLE;
               q_next.hold_full = 1'b0;
            end
         end
      endcase

      // Register writes; status write-one clears sticky errors
      if (i_wr) begin
         unique case (i_addr)
            `SPB_ADDR_CTRL: q_next.ctrl = i_wdata[6:0];
            `SPB_ADDR_BAUD: q_next.baud = i_wdata[DIV_W-1:0];
            `SPB_ADDR_DATA: begin
               // A byte written while one waits replaces it
               q_next.sw_pend = 1'b1;
               q_next.sw_byte = i_wdata[7:0];
            end
            `SPB_ADDR_STATUS: begin
               if (i_wdata[`SPB_ST_OVERRUN])  q_next.overrun   = 1'b0;
               if (i_wdata[`SPB_ST_FRAMEERR]) q_next.frame_err = 1'b0;
            end
            default: ;
         endcase
      end

      // Received character; set wins over any clear above
      if (rx_ferr) q_next.frame_err = 1'b1;
      if (rx_valid) begin
         if (q_reg.hold_full && !deliver) begin
            q_next.overrun = 1'b1;
         end else begin
            q_next.hold_full = 1'b1;
            q_next.hold      = rx_data;
         end
      end

      // Read data in the cycle after the strobe, zero elsewhere
      if (i_rd) begin
         unique case (i_addr)
            `SPB_ADDR_CTRL:   q_next.rdata = {25'h0, q_reg.ctrl};
            `SPB_ADDR_BAUD:   q_next.rdata = 32'(q_reg.baud);
            `SPB_ADDR_DATA:   q_next.rdata = {24'h0, q_reg.hold};
            `SPB_ADDR_STATUS: begin
               q_next.rdata[`SPB_ST_LINK]     = q_reg.link;
               q_next.rdata[`SPB_ST_READY]    = q_reg.hold_full;
               q_next.rdata[`SPB_ST_OVERRUN]  = q_reg.overrun;
               q_next.rdata[`SPB_ST_STROBE]   = (q_reg.pst == PAR_STROBE);
               q_next.rdata[`SPB_ST_TXBUSY]   = tx_busy;
               q_next.rdata[`SPB_ST_ONLINE]   = i_par.online;
               q_next.rdata[`SPB_ST_FRAMEERR] = q_reg.frame_err;
            end
            default: ;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q_reg      <= '0;
         q_reg.ctrl <= `SPB_CTRL_RST;
         q_reg.baud <= DIV_W'(`SPB_BAUD_DIV);
         q_reg.pst  <= PAR_IDLE;
      end else begin
         q_reg <= q_next;
      end
   end

   // ****************************************
   // Serial engines
   // ****************************************
   spb_uart_rx #(.DIV_W(DIV_W)) u_rx (
      .i_clk_sys   (i_clk_sys),
      .i_rst_n     (i_rst_n),
      .i_en        (rx_en),
      .i_rxd       (rx_line),
      .i_div       (q_reg.baud),
      .o_valid     (rx_valid),
      .o_frame_err (rx_ferr),
      .o_data      (rx_data)
   );

   spb_uart_tx #(.DIV_W(DIV_W)) u_tx (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_start   (tx_start),
      .i_byte    (tx_byte),
      .i_div     (q_reg.baud),
      .o_txd     (tx_line),
      .o_busy    (tx_busy)
   );

   // ****************************************
   // Pin drive
   // ****************************************
   // Modem lines low while linked; secondary request shows free hold
   assign o_mdm.dtr_n  = !q_reg.link;
   assign o_mdm.rts_n  = !q_reg.link;
   assign o_mdm.srts_n = !(q_reg.link && !q_reg.hold_full);
   // Each line idles at mark when its method is not selected
   assign o_mdm.txd    = loop_mode ? 1'b1 : tx_line;
   assign o_mdm.aloop  = loop_mode ? tx_line : 1'b1;
   assign o_mdm.ploop  = loop_mode && q_reg.link &&
                         !q_reg.hold_full;

   // Data straight from the hold; strobe polarity per card type
   assign o_par.data   = q_reg.hold;
   assign o_par.strobe = (q_reg.pst == PAR_STROBE) ^ vertical_format_option;

   // Read data straight from its flop; zero outside the answer cycle
   // so a late sample reads as empty rather than stale
   assign o_rdata      = q_reg.rdata;

endmodule // spb_bridge

// *** verilog/spb_uart_rx.sv ***
// Holds the asynchronous character receiver: start edge, 8 data bits
// LSB first, one stop bit.
// Assumes i_rxd synchronous to i_clk_sys and i_div of at least 2.
`timescale 1ns/1ps
module spb_uart_rx #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_n,
   // Line and setup
   input  wire logic             i_en,
   input  wire logic             i_rxd,
   input  wire logic [DIV_W-1:0] i_div,
   // Character out
   output logic                  o_valid,
   output logic                  o_frame_err,
   output logic [7:0]            o_data
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
      spb_rx_st_t;
   typedef struct packed {
      spb_rx_st_t       st;
      logic [DIV_W-1:0] cnt;
      logic [2:0]       idx;
      logic [7:0]       sh;
      logic             prev;
      logic             valid;
      logic             ferr;
   } spb_rx_state_t;

   spb_rx_state_t q_reg, q_next;

   // Counter must hold at least a half-bit of a few cycles
   if (DIV_W < 4) $error("spb_uart_rx: DIV_W too small");

   // Bit timing and framing
   always_comb begin
      q_next       = q_reg;
      q_next.prev  = i_rxd;
      q_next.valid = 1'b0;
      q_next.ferr  = 1'b0;
      unique case (q_reg.st)
         RX_IDLE: begin
            // Falling edge of the idle-high line opens a character
            if (i_en && q_reg.prev && !i_rxd) begin
               q_next.st  = RX_START;
               q_next.cnt = i_div >> 1;
            end
         end
         RX_START: begin
            if (q_reg.cnt == '0) begin
               // A glitch shorter than half a bit is not a start
               q_next.st  = i_rxd ? RX_IDLE : RX_DATA;
               q_next.cnt = i_div - DIV_W'(1);
               q_next.idx = 3'h0;
            end else begin
               q_next.cnt = q_reg.cnt - DIV_W'(1);
            end
         end
         RX_DATA: begin
            if (q_reg.cnt == '0) begin
               q_next.sh  = {i_rxd, q_reg.sh[7:1]};
               q_next.cnt = i_div - DIV_W'(1);
               q_next.idx = q_reg.idx + 3'h1;
               if (q_reg.idx == 3'h7) q_next.st = RX_STOP;
            end else begin
               q_next.cnt = q_reg.cnt - DIV_W'(1);
            end
         end
         RX_STOP: begin
            if (q_reg.cnt == '0) begin
               q_next.valid = i_rxd;
               q_next.ferr  = !i_rxd;
               q_next.st    = RX_IDLE;
            end else begin
               q_next.cnt = q_reg.cnt - DIV_W'(1);
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q_reg <= '{st: RX_IDLE, prev: 1'b1, default: '0};
      end else begin
         q_reg <= q_next;
      end
   end

   assign o_valid     = q_reg.valid;
   assign o_frame_err = q_reg.ferr;
   assign o_data      = q_reg.sh;

endmodule // spb_uart_rx

// *** verilog/spb_uart_tx.sv ***
// Holds the asynchronous character transmitter, 8N1, LSB first.
// Assumes i_start only while o_busy is low and i_div of at least 2.
`timescale 1ns/1ps
module spb_uart_tx #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_n,
   // Request
   input  wire logic             i_start,
   input  wire logic [7:0]       i_byte,
   input  wire logic [DIV_W-1:0] i_div,
   // Line
   output logic                  o_txd,
   output logic                  o_busy
);
   typedef struct packed {
      logic             busy;
      logic [DIV_W-1:0] cnt;
      logic [3:0]       n;
      logic [9:0]       sh;
   } spb_tx_state_t;

   spb_tx_state_t q_reg, q_next;

   if (DIV_W < 4) $error("spb_uart_tx: DIV_W too small");

   // Shift out start, data and stop; idle line is mark
   always_comb begin
      q_next = q_reg;
      if (!q_reg.busy) begin
         if (i_start) begin
            q_next.busy = 1'b1;
            q_next.sh   = {1'b1, i_byte, 1'b0};
            q_next.cnt  = i_div - DIV_W'(1);
            q_next.n    = 4'h0;
         end
      end else if (q_reg.cnt == '0) begin
         q_next.sh  = {1'b1, q_reg.sh[9:1]};
         q_next.cnt = i_div - DIV_W'(1);
         q_next.n   = q_reg.n + 4'h1;
         if (q_reg.n == 4'h9) q_next.busy = 1'b0;
      end else begin
         q_next.cnt = q_reg.cnt - DIV_W'(1);
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q_reg <= '{sh: 10'h3FF, default: '0};
      end else begin
         q_reg <= q_next;
      end
   end

   assign o_txd  = q_reg.sh[0];
   assign o_busy = q_reg.busy;

endmodule // spb_uart_tx
